// File: ido_ctrl.sv
// Overview of operation
// RULE1: dma requests for data bytes go out only while dma_request_enable is set, and dma_last_transfer marks the next one as final.
// RULE2: with buffer_irq_enable set, transmit-empty or receive-full raises the buffer interrupt.
// RULE3: with event_irq_enable set, start sent, short address match, long header sent or stop seen raise the event interrupt.
// RULE4: with event_irq_enable set, transfer done alone also raises the event interrupt when neither buffer condition is present.
// RULE5: with both event and buffer enables set, transmit-empty and receive-full also raise the event interrupt.
// RULE6: an 8-bit input_clock_mhz field holds the clock rate in whole MHz, supported from 2 to 120, for the timing generator.
// RULE7: software must program input_clock_mhz to the real clock rate before bus use or the timings are wrong.
// RULE8: the primary own address is 10 bits with a width select, and in 7-bit mode bit 0 and bits 9:8 are ignored.
// RULE9: in 7-bit mode the second own address in bits 7:1 is also answered, only while second_addr_enable is 1.
// RULE10: bits 15:13 of the control register always read zero whatever is written.
// RULE11: with error_irq_enable set, bus error, arbitration loss, no acknowledge, overrun, checksum error, timeout or alert raise the error interrupt.
//
// Design decisions made here: the Wishbone interface to the registers and the register addresses.
`include "ido_consts.svh"
`timescale 1ns/100ps
`default_nettype none

module ido_ctrl (
    // clock, reset, enable
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // classic wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [`IDO_ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // flags from the byte engine
    input wire ido_pkg::ido_flags_t flags_i,
    // received address from the serial side
    input wire logic [9:0] rx_addr_i,
    input wire logic rx_long_i,
    input wire logic rx_addr_valid_i,
    // dma side
    output logic dma_tx_req_o,
    output logic dma_rx_req_o,
    output logic dma_last_o,
    // timing generator side
    output logic [7:0] clk_mhz_o,
    output logic clk_mhz_ok_o,
    // own address results
    output ido_pkg::ido_own_addr_t own_addr_o,
    output logic addr_match_o,
    output logic addr_second_o,
    // interrupt lines
    output logic buffer_irq_o,
    output logic event_irq_o,
    output logic error_irq_o,
    output logic irq_o
);

    logic [15:0] ctrl_q;
    logic [15:0] oadr1_q;
    logic [15:0] oadr2_q;
    logic [`IDO_IRQ_W-1:0] ists_q;
    logic [`IDO_IRQ_W-1:0] ists_d;
    logic [`IDO_IRQ_W-1:0] imsk_q;
    logic [`IDO_IRQ_W-1:0] ev_now;
    logic [`IDO_IRQ_W-1:0] ev_prev_q;
    logic [`IDO_IRQ_W-1:0] ev_rise;
    logic ack_q;
    logic [31:0] dat_q;
    logic [31:0] rd_d;
    logic bus_req;
    logic wr_en;
    logic match_d;
    logic second_d;
    logic match_q;
    logic second_q;
    logic match_pulse_q;
    logic buf_cond;
    logic evt_cond;
    logic err_cond;
    ido_pkg::ido_own_addr_t own_cfg;

    // merge write data into a 16-bit register under the byte enables
    function automatic logic [15:0] lane_merge(input logic [15:0] old,
                                               input logic [31:0] wdat,
                                               input logic [3:0] sel);
        lane_merge = old;
        if (sel[0]) begin
            lane_merge[7:0] = wdat[7:0];
        end
        if (sel[1]) begin
            lane_merge[15:8] = wdat[15:8];
        end
    endfunction : lane_merge

    // write strobe for one register word
    function automatic logic reg_wr(input logic en,
                                    input logic [`IDO_ADR_W-1:0] adr,
                                    input logic [`IDO_ADR_W-1:0] reg_adr);
        reg_wr = en && (adr == reg_adr);
    endfunction : reg_wr

    assign bus_req = wb_cyc_i && wb_stb_i && !ack_q;
    assign wr_en = bus_req && wb_we_i && ce_i;

    // one wait state; ack drops the cycle after it was given
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
        end else if (ce_i) begin
            ack_q <= bus_req;
        end
    end

    always_comb begin
        rd_d = 32'h0000_0000;
        case (wb_adr_i)
            `IDO_ADR_CTRL: begin
                rd_d[15:0] = ctrl_q;
                rd_d[`IDO_CTRL_RSV_HI:`IDO_CTRL_RSV_LO] = 3'h0; // RULE10
            end
            `IDO_ADR_OADR1: rd_d[15:0] = oadr1_q;
            `IDO_ADR_OADR2: rd_d[15:0] = oadr2_q;
            `IDO_ADR_ISTS: rd_d[`IDO_IRQ_W-1:0] = ists_q;
            `IDO_ADR_IMSK: rd_d[`IDO_IRQ_W-1:0] = imsk_q;
            default: rd_d = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_q <= 32'h0000_0000;
        end else if (ce_i && bus_req && !wb_we_i) begin
            dat_q <= rd_d;
        end
    end

    assign wb_dat_o = dat_q;
    assign wb_ack_o = ack_q;

    // control register; reserved top bits are never stored
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q <= `IDO_CTRL_RST;
        end else if (reg_wr(wr_en, wb_adr_i, `IDO_ADR_CTRL)) begin
            ctrl_q <= lane_merge(ctrl_q, wb_dat_i, wb_sel_i) & `IDO_CTRL_WMASK; // RULE10
        end
    end

    // primary own address; bits 14:10 are reserved and kept at zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            oadr1_q <= `IDO_OA1_RST;
        end else if (reg_wr(wr_en, wb_adr_i, `IDO_ADR_OADR1)) begin
            oadr1_q <= lane_merge(oadr1_q, wb_dat_i, wb_sel_i) & `IDO_OA1_WMASK; // RULE8
        end
    end

    // second own address; upper byte reserved
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            oadr2_q <= `IDO_OA2_RST;
        end else if (reg_wr(wr_en, wb_adr_i, `IDO_ADR_OADR2)) begin
            oadr2_q <= lane_merge(oadr2_q, wb_dat_i, wb_sel_i) & `IDO_OA2_WMASK; // RULE9
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            imsk_q <= `IDO_IRQ_RST;
        end else if (reg_wr(wr_en && wb_sel_i[0], wb_adr_i, `IDO_ADR_IMSK)) begin
            imsk_q <= wb_dat_i[`IDO_IRQ_W-1:0];
        end
    end

    // the timing generator divides from this; a wrong value gives wrong bus timing
    assign clk_mhz_o = ctrl_q[`IDO_CTRL_MHZ_HI:`IDO_CTRL_MHZ_LO]; // RULE6
    assign clk_mhz_ok_o = (clk_mhz_o >= `IDO_MHZ_MIN)
                          && (clk_mhz_o <= `IDO_MHZ_MAX); // RULE7

    // dma requests follow the buffer flags only while enabled
    assign dma_tx_req_o = ctrl_q[`IDO_CTRL_DMA_REQUEST_ENABLE] && flags_i.transmit_buffer_empty; // RULE1
    assign dma_rx_req_o = ctrl_q[`IDO_CTRL_DMA_REQUEST_ENABLE] && flags_i.receive_buffer_full; // RULE1
    assign dma_last_o = ctrl_q[`IDO_CTRL_LAST]; // RULE1

    assign buf_cond = flags_i.transmit_buffer_empty || flags_i.receive_buffer_full;

    assign buffer_irq_o = ctrl_q[`IDO_CTRL_BUFIE] && buf_cond; // RULE2

    always_comb begin
        evt_cond = flags_i.start_sent_flag
                   || flags_i.short_address_match_flag
                   || flags_i.long_header_sent_flag
                   || flags_i.stop_seen_flag; // RULE3
        if (flags_i.transfer_done_flag && !buf_cond) begin
            evt_cond = 1'b1; // RULE4
        end
        if (ctrl_q[`IDO_CTRL_BUFIE] && buf_cond) begin
            evt_cond = 1'b1; // RULE5
        end
    end

    assign event_irq_o = ctrl_q[`IDO_CTRL_EVTIE] && evt_cond; // RULE3

    assign err_cond = flags_i.bus_error_flag
                      || flags_i.arbitration_loss_flag
                      || flags_i.no_acknowledge_flag
                      || flags_i.overrun_flag
                      || flags_i.checksum_error_flag
                      || flags_i.bus_timeout_flag
                      || flags_i.bus_alert_flag;

    assign error_irq_o = ctrl_q[`IDO_CTRL_ERRIE] && err_cond; // RULE11

    // own address decode
    assign own_cfg.primary_address_width_sel = oadr1_q[`IDO_OA1_MODE];
    assign own_cfg.primary_own_addr = oadr1_q[`IDO_OA1_ADR_HI:`IDO_OA1_ADR_LO];
    assign own_cfg.second_own_addr = oadr2_q[`IDO_OA2_ADR_HI:`IDO_OA2_ADR_LO];
    assign own_cfg.second_addr_enable = oadr2_q[`IDO_OA2_EN];
    assign own_addr_o = own_cfg;

    ido_addr_match u_match (
        .cfg_i(own_cfg),
        .rx_addr_i(rx_addr_i),
        .rx_long_i(rx_long_i),
        .match_o(match_d),
        .second_hit_o(second_d)
    );

    // result is held until the next received address
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            match_q <= 1'b0;
            second_q <= 1'b0;
            match_pulse_q <= 1'b0;
        end else if (ce_i) begin
            match_pulse_q <= rx_addr_valid_i && match_d;
            if (rx_addr_valid_i) begin
                match_q <= match_d; // RULE8
                second_q <= second_d; // RULE9
            end
        end
    end

    assign addr_match_o = match_q;
    assign addr_second_o = second_q;

    // sticky status: a level line that stays high sets its bit only once,
    // so software can clear it and not be re-interrupted by the same level
    always_comb begin
        ev_now = `IDO_IRQ_RST;
        ev_now[`IDO_IRQ_BUF] = buffer_irq_o;
        ev_now[`IDO_IRQ_EVT] = event_irq_o;
        ev_now[`IDO_IRQ_ERR] = error_irq_o;
        ev_now[`IDO_IRQ_MATCH] = 1'b0;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ev_prev_q <= `IDO_IRQ_RST;
        end else if (ce_i) begin
            ev_prev_q <= ev_now;
        end
    end

    always_comb begin
        ev_rise = ev_now & ~ev_prev_q;
        ev_rise[`IDO_IRQ_MATCH] = match_pulse_q;
        ists_d = ists_q;
        if (reg_wr(wr_en && wb_sel_i[0], wb_adr_i, `IDO_ADR_ISTS)) begin
            ists_d = ists_d & ~wb_dat_i[`IDO_IRQ_W-1:0];
        end
        // a new event in the clearing cycle is kept
        ists_d = ists_d | ev_rise;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ists_q <= `IDO_IRQ_RST;
        end else if (ce_i) begin
            ists_q <= ists_d;
        end
    end

    assign irq_o = |(ists_q & imsk_q);

endmodule : ido_ctrl

`default_nettype wire

// File: ido_consts.svh
`ifndef IDO_CONSTS_SVH
`define IDO_CONSTS_SVH

// register byte addresses
`define IDO_ADR_CTRL 8'h00
`define IDO_ADR_OADR1 8'h04
`define IDO_ADR_OADR2 8'h08
`define IDO_ADR_ISTS 8'h0C
`define IDO_ADR_IMSK 8'h10
`define IDO_ADR_W 8

// control register fields
`define IDO_CTRL_LAST 12
`define IDO_CTRL_DMA_REQUEST_ENABLE 11
`define IDO_CTRL_BUFIE 10
`define IDO_CTRL_EVTIE 9
`define IDO_CTRL_ERRIE 8
`define IDO_CTRL_RSV_HI 15
`define IDO_CTRL_RSV_LO 13
`define IDO_CTRL_RST 16'h0000
`define IDO_CTRL_WMASK 16'h1FFF
`define IDO_CTRL_MHZ_HI 7
`define IDO_CTRL_MHZ_LO 0

// own address fields
`define IDO_OA1_MODE 15
`define IDO_OA1_RST 16'h0000
`define IDO_OA1_WMASK 16'h83FF
`define IDO_OA1_ADR_HI 9
`define IDO_OA1_ADR_LO 0
`define IDO_OA2_EN 0
`define IDO_OA2_RST 16'h0000
`define IDO_OA2_WMASK 16'h00FF
`define IDO_OA2_ADR_HI 7
`define IDO_OA2_ADR_LO 1

// input clock setting limits in MHz
`define IDO_MHZ_MIN 8'h02
`define IDO_MHZ_MAX 8'h78

// interrupt status bits
`define IDO_IRQ_BUF 0
`define IDO_IRQ_EVT 1
`define IDO_IRQ_ERR 2
`define IDO_IRQ_MATCH 3
`define IDO_IRQ_W 4
`define IDO_IRQ_RST 4'h0

`endif

// File: ido_pkg.sv
package ido_pkg;

    // status flags delivered by the byte engine of the controller
    typedef struct packed {
        logic transmit_buffer_empty;
        logic receive_buffer_full;
        logic start_sent_flag;
        logic short_address_match_flag;
        logic long_header_sent_flag;
        logic stop_seen_flag;
        logic transfer_done_flag;
        logic bus_error_flag;
        logic arbitration_loss_flag;
        logic no_acknowledge_flag;
        logic overrun_flag;
        logic checksum_error_flag;
        logic bus_timeout_flag;
        logic bus_alert_flag;
    } ido_flags_t;

    // own address configuration as seen by the matcher
    typedef struct packed {
        logic primary_address_width_sel;
        logic [9:0] primary_own_addr;
        logic [6:0] second_own_addr;
        logic second_addr_enable;
    } ido_own_addr_t;

    // 7-bit compare of a received address byte against an own address
    function automatic logic addr7_eq(input logic [6:0] rx, input logic [6:0] own);
        addr7_eq = (rx == own);
    endfunction : addr7_eq

endpackage : ido_pkg

// File: ido_addr_match.sv
`timescale 1ns/100ps
`default_nettype none

module ido_addr_match (
    // configuration
    input wire ido_pkg::ido_own_addr_t cfg_i,
    // received address
    input wire logic [9:0] rx_addr_i,
    input wire logic rx_long_i,
    // result
    output logic match_o,
    output logic second_hit_o
);

    logic hit_primary7;
    logic hit_second7;
    logic hit_long;

    // 7-bit mode looks only at bits 7:1 of the primary address
    assign hit_primary7 = ido_pkg::addr7_eq(rx_addr_i[7:1], cfg_i.primary_own_addr[7:1]); // RULE8
    assign hit_second7 = cfg_i.second_addr_enable
                         && ido_pkg::addr7_eq(rx_addr_i[7:1], cfg_i.second_own_addr); // RULE9
    assign hit_long = (rx_addr_i == cfg_i.primary_own_addr);

    always_comb begin
        if (cfg_i.primary_address_width_sel) begin
            match_o = rx_long_i && hit_long; // RULE8
            second_hit_o = 1'b0;
        end else begin
            match_o = !rx_long_i && (hit_primary7 || hit_second7); // RULE9
            second_hit_o = !rx_long_i && !hit_primary7 && hit_second7;
        end
    end

endmodule : ido_addr_match

`default_nettype wire

// File: ido_ctrl_asserts.sv
`include "ido_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module ido_ctrl_asserts (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // bus
    input wire logic wb_we_i,
    input wire logic [`IDO_ADR_W-1:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // serial side
    input wire ido_pkg::ido_flags_t flags_i,
    input wire logic [9:0] rx_addr_i,
    input wire logic rx_long_i,
    input wire logic rx_addr_valid_i,
    // results
    input wire logic dma_tx_req_o,
    input wire logic dma_rx_req_o,
    input wire logic [7:0] clk_mhz_o,
    input wire logic clk_mhz_ok_o,
    input wire ido_pkg::ido_own_addr_t own_addr_o,
    input wire logic addr_match_o,
    input wire logic addr_second_o,
    input wire logic buffer_irq_o,
    input wire logic event_irq_o,
    input wire logic error_irq_o
);
    logic [13:0] fv;
    logic tk;
    assign fv = flags_i;
    assign tk = rx_addr_valid_i && ce_i;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_dma_tx_gate:
        assert property (dma_tx_req_o |-> fv[13]) else $error("tx request without empty buffer");
    a_dma_rx_gate:
        assert property (dma_rx_req_o |-> fv[12]) else $error("rx request without full buffer");
    a_buf_irq_src:
        assert property (buffer_irq_o |-> |fv[13:12]) else $error("buffer irq without cause");
    a_evt_irq_src:
        assert property (event_irq_o |-> |fv[11:8] || (fv[7] && !fv[13] && !fv[12]) || buffer_irq_o)
            else $error("event irq without cause");
    a_err_irq_src:
        assert property (error_irq_o |-> |fv[6:0]) else $error("error irq without cause");
    a_clk_range_ok:
        assert property (clk_mhz_ok_o == (clk_mhz_o >= 8'h02 && clk_mhz_o <= 8'h78))
            else $error("clock range flag wrong");
    a_ctrl_rsv_zero:
        assert property (wb_ack_o && !wb_we_i && wb_adr_i == 8'h00 |-> wb_dat_o[31:13] == 19'h0)
            else $error("control reserved bits not zero");
    a_short_match_hit:
        assert property (tk && !own_addr_o.primary_address_width_sel && !rx_long_i
            && rx_addr_i[7:1] == own_addr_o.primary_own_addr[7:1] |=> addr_match_o)
            else $error("short own address missed");
    a_second_off_miss:
        assert property (tk && !own_addr_o.second_addr_enable |=> !addr_second_o)
            else $error("second address hit while disabled");
    a_long_mode_short:
        assert property (tk && own_addr_o.primary_address_width_sel && !rx_long_i |=> !addr_match_o)
            else $error("short address matched in long mode");
endmodule : ido_ctrl_asserts
bind ido_ctrl ido_ctrl_asserts u_chk (.clk_i, .rst_i, .ce_i, .wb_we_i, .wb_adr_i, .wb_dat_o,
    .wb_ack_o, .flags_i, .rx_addr_i, .rx_long_i, .rx_addr_valid_i, .dma_tx_req_o, .dma_rx_req_o,
    .clk_mhz_o, .clk_mhz_ok_o, .own_addr_o, .addr_match_o, .addr_second_o, .buffer_irq_o,
    .event_irq_o, .error_irq_o);
`default_nettype wire

// File: ido_far_model.sv
`timescale 1ns/100ps
`default_nettype none
module ido_far_model (
    // clock
    input wire logic clk_i,
    // towards the controller
    output var ido_pkg::ido_flags_t flags_o,
    output logic [9:0] rx_addr_o,
    output logic rx_long_o,
    output logic rx_valid_o
);
    initial begin
        flags_o = '0;
        rx_addr_o = 10'h155;
        rx_long_o = 1'b0;
        rx_valid_o = 1'b0;
    end
    task put(input logic [13:0] f);
        flags_o <= f;
    endtask : put
    task send(input logic [9:0] a, input logic l);
        rx_addr_o <= a;
        rx_long_o <= l;
        rx_valid_o <= 1'b1;
        @(posedge clk_i);
        // once the strobe is gone the address is stale, so never leave it looking valid
        rx_addr_o <= ~a;
        rx_long_o <= ~l;
        rx_valid_o <= 1'b0;
    endtask : send
endmodule : ido_far_model
`default_nettype wire

// File: ido_ctrl_tb.sv
`include "ido_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module ido_ctrl_tb;
    logic clk_i, rst_i, cyc, stb, we, ack, dtx, drx, dlast, mok, mt, sc, bi, ei, xi, irq;
    logic [7:0] adr, mhz;
    logic [31:0] wdat, rdat, q;
    logic [13:0] f;
    logic [9:0] rxa;
    logic rxl, rxv;
    ido_pkg::ido_flags_t flags;
    logic ce;
    logic [3:0] sel;
    ido_pkg::ido_own_addr_t oa;
    int miscompares = 0;
    int checks_done = 0;
    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end
    ido_ctrl dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .flags_i(flags), .rx_addr_i(rxa), .rx_long_i(rxl),
        .rx_addr_valid_i(rxv), .dma_tx_req_o(dtx), .dma_rx_req_o(drx), .dma_last_o(dlast),
        .clk_mhz_o(mhz), .clk_mhz_ok_o(mok), .own_addr_o(oa), .addr_match_o(mt),
        .addr_second_o(sc), .buffer_irq_o(bi), .event_irq_o(ei), .error_irq_o(xi), .irq_o(irq));
    ido_far_model far (.clk_i(clk_i), .flags_o(flags), .rx_addr_o(rxa), .rx_long_o(rxl),
        .rx_valid_o(rxv));
    task wrap_up;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : wrap_up
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        @(posedge clk_i iff ack === 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
    endtask : wb
    task rd(input logic [7:0] a, input logic [31:0] e, input string n);
        wb(1'b0, a, 32'h0);
        chk(n, e, q);
    endtask : rd
    task step;
        repeat (2) @(posedge clk_i);
    endtask : step
    initial begin
        repeat (20000) @(posedge clk_i);
        miscompares++;
        wrap_up;
    end
    initial begin
        {cyc, stb, we, adr, wdat} = '0;
        ce = 1'b1;
        sel = 4'h3;
        rst_i = 1'b1;
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rd(`IDO_ADR_CTRL, 32'h0, "ctrl_rst");
        rd(`IDO_ADR_OADR1, 32'h0, "oadr1_rst");
        rd(8'h14, 32'h0, "unmapped");
        wb(1'b1, `IDO_ADR_CTRL, 32'hFFFFFFFF);
        rd(`IDO_ADR_CTRL, 32'h1FFF, "ctrl_rsv");
        for (int i = 0; i < 4; i++) begin
            f[7:0] = (i == 0) ? 8'h01 : (i == 1) ? 8'h02 : (i == 2) ? 8'h78 : 8'h79;
            wb(1'b1, `IDO_ADR_CTRL, {24'h0, f[7:0]});
            chk("mhz_ok", (i == 1 || i == 2), mok);
            chk("mhz", f[7:0], mhz);
        end
        wb(1'b1, `IDO_ADR_CTRL, 32'h1810);
        far.put(14'h3000);
        step;
        chk("dma", 3'h7, {dtx, drx, dlast});
        wb(1'b1, `IDO_ADR_CTRL, 32'h0010);
        chk("dma_off", 3'h0, {dtx, drx, dlast});
        for (int e = 0; e < 8; e++) begin
            wb(1'b1, `IDO_ADR_CTRL, {21'h0, e[2:0], 8'h10});
            for (int i = 0; i < 14; i++) begin
                f = 14'h1 << i;
                far.put(f);
                step;
                chk("buf_irq", e[2] & |f[13:12], bi);
                chk("evt_irq", e[1] & (|f[11:7] | (e[2] & |f[13:12])), ei);
                chk("err_irq", e[0] & |f[6:0], xi);
            end
        end
        wb(1'b1, `IDO_ADR_CTRL, 32'h0210);
        far.put(14'h2080);
        step;
        chk("evt_tdc_busy", 1'b0, ei);
        far.put(14'h0);
        wb(1'b1, `IDO_ADR_ISTS, 32'hF);
        wb(1'b1, `IDO_ADR_IMSK, 32'h4);
        wb(1'b1, `IDO_ADR_CTRL, 32'h0110);
        far.put(14'h0040);
        step;
        @(posedge clk_i);
        chk("irq_on", 1'b1, irq);
        rd(`IDO_ADR_ISTS, 32'h4, "status");
        wb(1'b1, `IDO_ADR_IMSK, 32'h0);
        chk("irq_mask", 1'b0, irq);
        wb(1'b1, `IDO_ADR_IMSK, 32'h4);
        wb(1'b1, `IDO_ADR_ISTS, 32'h4);
        rd(`IDO_ADR_ISTS, 32'h0, "status_clr");
        chk("irq_clr", 1'b0, irq);
        wb(1'b1, `IDO_ADR_OADR1, 32'hFFFF);
        rd(`IDO_ADR_OADR1, 32'h83FF, "oadr1_rw");
        wb(1'b1, `IDO_ADR_OADR2, 32'hFFFF);
        rd(`IDO_ADR_OADR2, 32'h00FF, "oadr2_rw");
        sel <= 4'h1;
        wb(1'b1, `IDO_ADR_OADR1, 32'h0);
        sel <= 4'h0;
        wb(1'b1, `IDO_ADR_OADR1, 32'h0);
        sel <= 4'h3;
        rd(`IDO_ADR_OADR1, 32'h8300, "oadr1_lanes");
        wb(1'b1, `IDO_ADR_OADR1, 32'h0375);
        wb(1'b1, `IDO_ADR_OADR2, 32'h00A2);
        chk("own_addr", {1'b0, 10'h375, 7'h51, 1'b0}, oa);
        far.send(10'h074, 1'b0);
        step;
        chk("match_short", 2'h2, {mt, sc});
        rd(`IDO_ADR_ISTS, 32'h8, "status_match");
        far.send(10'h0A2, 1'b0);
        step;
        chk("second_off", 2'h0, {mt, sc});
        wb(1'b1, `IDO_ADR_OADR2, 32'h00A3);
        far.send(10'h0A2, 1'b0);
        step;
        chk("second_on", 2'h3, {mt, sc});
        wb(1'b1, `IDO_ADR_OADR1, 32'h82F5);
        far.send(10'h2F5, 1'b1);
        step;
        chk("match_long", 2'h2, {mt, sc});
        far.send(10'h0A2, 1'b0);
        step;
        chk("second_long", 2'h0, {mt, sc});
        ce <= 1'b0;
        far.send(10'h2F5, 1'b1);
        step;
        chk("ce_freeze", 2'h0, {mt, sc});
        ce <= 1'b1;
        far.send(10'h2F5, 1'b1);
        step;
        chk("ce_thaw", 2'h2, {mt, sc});
        wrap_up;
    end
endmodule : ido_ctrl_tb
`default_nettype wire
